// ---- tfc_pkg.sv ----
// Constants, types and helper functions of the time and frequency core.
//
// Contract
// - Keep days-to-100 ns time from 10 MHz.
// - Answer time reads with no wait states.
// - Flywheel on internal oscillator when reference lost.
// - Exact time match drives output and interrupt.
// - Three event inputs each latch running time.
// - Completed event capture raises an interrupt.
// - Host signal timestamped for later reading.
// - Programmable rate synthesizer over very wide range.
// - Rate setting resolution 1/32 Hz or finer.
// - Synthesized rate goes to pin or interrupt.
// - Fixed 1, 5 or 10 MPPS output.
// - Time read in binary or decimal form; decimal covers hr, min and sec only, days and sub stay binary.
// - Generator mode runs from external 10 MHz.
// - Drive DAC word to steer the oscillator.
package tfc_pkg;

  // ==========================================================
  // Timing base
  localparam int CLK_HZ = 10_000_000;
  localparam int LSB_NS = 100;
  localparam logic [23:0] SUB_LAST = 24'(1_000_000_000 / LSB_NS - 1);
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [4:0] HR_LAST = 5'h17;

  // ==========================================================
  // Time value
  typedef struct packed {
    logic [15:0] days;
    logic [4:0] hr;
    logic [5:0] min;
    logic [5:0] sec;
    logic [23:0] sub;
  } time_t;

  localparam time_t TIME_ZERO = '0;

  // ==========================================================
  // Read word selects
  localparam logic [3:0] SEL_TIME_HI = 4'h0;
  localparam logic [3:0] SEL_TIME_LO = 4'h1;
  localparam logic [3:0] SEL_STAMP_BASE = 4'h2;
  localparam int N_STAMP = 4;
  localparam int HOST_STAMP = 3;

  // ==========================================================
  // Interrupt sources
  localparam int N_IRQ = 5;
  localparam int IRQ_CMP = 0;
  localparam int IRQ_EVT0 = 1;
  localparam int IRQ_RATE = 4;
  localparam int N_EVT = 3;

  // ==========================================================
  // Rate synthesizer and fixed rate
  localparam int DDS_W = 48;
  localparam logic ROUTE_PIN = 1'b0;
  localparam logic ROUTE_IRQ = 1'b1;
  localparam logic [1:0] FIX_10M = 2'h0;
  localparam logic [1:0] FIX_5M = 2'h1;
  localparam logic [1:0] FIX_1M = 2'h2;
  localparam logic [3:0] DIV_10M = 4'h1;
  localparam logic [3:0] DIV_5M = 4'h2;
  localparam logic [3:0] DIV_1M = 4'hA;
  localparam int DAC_W = 16;

  // ==========================================================
  // Functions
  function automatic logic [7:0] bcd8(input logic [7:0] v);
    logic [7:0] tens;
    tens = v / 8'h0A;
    return {tens[3:0], 4'(v - tens * 8'h0A)};
  endfunction

  function automatic logic [7:0] fmt8(input logic [7:0] v,
                                      input logic dec);
    return dec ? bcd8(v) : v;
  endfunction

  function automatic logic [31:0] word_hi(input time_t t, input logic dec);
    return {t.days, fmt8({3'h0, t.hr}, dec), fmt8({2'h0, t.min}, dec)};
  endfunction

  function automatic logic [31:0] word_lo(input time_t t, input logic dec);
    return {fmt8({2'h0, t.sec}, dec), t.sub};
  endfunction

  function automatic time_t inc_time(input time_t t);
    time_t n;
    n = t;
    if (t.sub != SUB_LAST) begin
      n.sub = t.sub + 24'h1;
    end else begin
      n.sub = 24'h0;
      if (t.sec != SEC_LAST) begin
        n.sec = t.sec + 6'h1;
      end else begin
        n.sec = 6'h0;
        if (t.min != MIN_LAST) begin
          n.min = t.min + 6'h1;
        end else begin
          n.min = 6'h0;
          if (t.hr != HR_LAST) begin
            n.hr = t.hr + 5'h1;
          end else begin
            n.hr = 5'h0;
            n.days = t.days + 16'h1;
          end
        end
      end
    end
    return n;
  endfunction

endpackage

// ---- rate_synth.sv ----
// Phase accumulator rate synthesizer.
`timescale 1ns/10ps
module rate_synth
  import tfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Tuning
  input wire logic [DDS_W-1:0] step,
  // Rate outputs
  output logic tick,
  output logic wave
);

  logic [DDS_W-1:0] acc_r;
  logic [DDS_W-1:0] acc_nxt;
  logic tick_r;
  logic tick_nxt;

  // A 48-bit accumulator gives steps near 36 nHz, fine enough for both
  // the 1/32 Hz resolution and a period of over 325 days.
  always_comb begin
    {tick_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, step};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_r <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
  assign wave = acc_r[DDS_W-1];

  chk_acc_step: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> acc_r == DDS_W'($past(acc_r) + $past(step)))
    else $error("Accumulator did not advance by the step.");

endmodule // rate_synth

// ---- time_frequency_core.sv ----
// Timekeeping core: time count, reads, compare, captures, rates and DAC.
`timescale 1ns/10ps
module time_frequency_core
  import tfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Time set
  input wire logic set_stb,
  input wire time_t set_time,
  // Reference
  input wire logic gen_mode,
  input wire logic ext_ok,
  input wire logic ext_tick,
  // Time read
  input wire logic rd_stb,
  input wire logic [3:0] rd_sel,
  input wire logic fmt_dec,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // Time compare
  input wire logic cmp_en,
  input wire time_t cmp_time,
  output logic cmp_out,
  // Events and host signal
  input wire logic [N_EVT-1:0] evt_in,
  input wire logic host_sig,
  // Interrupts
  input wire logic [N_IRQ-1:0] irq_en,
  input wire logic [N_IRQ-1:0] irq_clr,
  output logic [N_IRQ-1:0] irq_pend,
  output logic irq_out,
  // Rate synthesizer
  input wire logic [DDS_W-1:0] dds_step,
  input wire logic rate_route,
  output logic rate_out,
  // Fixed rate and DAC
  input wire logic [1:0] fix_sel,
  output logic fix_out,
  input wire logic [DAC_W-1:0] dac_set,
  output logic [DAC_W-1:0] dac_out
);

  // ==========================================================
  // Time count
  time_t time_r;
  time_t time_nxt;
  logic adv;

  // In generator mode the external 10 MHz paces the count; if it is lost
  // the count flywheels on the local clock rather than stopping.
  always_comb begin
    adv = (gen_mode && ext_ok) ? ext_tick : 1'b1;
    time_nxt = time_r;
    if (set_stb) begin
      time_nxt = set_time;
    end else if (adv) begin
      time_nxt = inc_time(time_r);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      time_r <= TIME_ZERO;
    end else begin
      time_r <= time_nxt;
    end
  end

  // ==========================================================
  // Compare, event and host captures
  time_t stamp_r [N_STAMP];
  time_t stamp_nxt [N_STAMP];
  logic [N_EVT-1:0] evt_prev_r;
  logic [N_EVT-1:0] evt_rise;
  logic cmp_seen_r;
  logic cmp_seen_nxt;
  logic cmp_hit;
  logic cmp_out_r;

  always_comb begin
    evt_rise = evt_in & ~evt_prev_r;
    cmp_seen_nxt = (time_r == cmp_time);
    cmp_hit = cmp_en && cmp_seen_nxt && !cmp_seen_r;
    for (int i = 0; i < N_STAMP; i++) begin
      stamp_nxt[i] = stamp_r[i];
    end
    for (int i = 0; i < N_EVT; i++) begin
      if (evt_rise[i]) begin
        stamp_nxt[i] = time_r;
      end
    end
    if (host_sig) begin
      stamp_nxt[HOST_STAMP] = time_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < N_STAMP; i++) begin
        stamp_r[i] <= TIME_ZERO;
      end
      evt_prev_r <= '0;
      cmp_seen_r <= 1'b0;
      cmp_out_r <= 1'b0;
    end else begin
      stamp_r <= stamp_nxt;
      evt_prev_r <= evt_in;
      cmp_seen_r <= cmp_seen_nxt;
      cmp_out_r <= cmp_hit;
    end
  end

  assign cmp_out = cmp_out_r;

  // ==========================================================
  // Host reads
  time_t snap_r;
  time_t snap_nxt;
  logic [31:0] rd_data_r;
  logic [31:0] rd_data_nxt;
  logic rd_valid_r;
  logic [3:0] sidx;

  // Reading the high word freezes the whole time so the low word that
  // follows cannot show a carry that happened between the two reads.
  always_comb begin
    snap_nxt = snap_r;
    rd_data_nxt = rd_data_r;
    sidx = rd_sel - SEL_STAMP_BASE;
    if (rd_stb) begin
      if (rd_sel == SEL_TIME_HI) begin
        snap_nxt = time_r;
        rd_data_nxt = word_hi(time_r, fmt_dec);
      end else if (rd_sel == SEL_TIME_LO) begin
        rd_data_nxt = word_lo(snap_r, fmt_dec);
      end else if (sidx[3:1] < 3'(N_STAMP)) begin
        if (sidx[0]) begin
          rd_data_nxt = word_lo(stamp_r[sidx[2:1]], fmt_dec);
        end else begin
          rd_data_nxt = word_hi(stamp_r[sidx[2:1]], fmt_dec);
        end
      end else begin
        rd_data_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      snap_r <= TIME_ZERO;
      rd_data_r <= 32'h0;
      rd_valid_r <= 1'b0;
    end else begin
      snap_r <= snap_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_stb;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // ==========================================================
  // Rate synthesizer
  logic rate_tick;
  logic rate_wave;
  logic rate_out_r;

  rate_synth i_rate_synth (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .step(dds_step),
    .tick(rate_tick),
    .wave(rate_wave)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rate_out_r <= 1'b0;
    end else begin
      rate_out_r <= (rate_route == ROUTE_PIN) && rate_wave;
    end
  end

  assign rate_out = rate_out_r;

  // ==========================================================
  // Interrupts
  logic [N_IRQ-1:0] pend_r;
  logic [N_IRQ-1:0] pend_nxt;
  logic [N_IRQ-1:0] pend_set;

  // A new event in the cycle of its clear keeps the flag set.
  always_comb begin
    pend_set = '0;
    pend_set[IRQ_CMP] = cmp_hit;
    pend_set[IRQ_EVT0 +: N_EVT] = evt_rise;
    pend_set[IRQ_RATE] = rate_tick && (rate_route == ROUTE_IRQ);
    pend_nxt = (pend_r & ~irq_clr) | pend_set;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign irq_pend = pend_r;
  assign irq_out = |(pend_r & irq_en);

  // ==========================================================
  // Fixed rate and DAC
  logic [3:0] fix_cnt_r;
  logic [3:0] fix_cnt_nxt;
  logic [3:0] fix_div;
  logic fix_out_r;
  logic [DAC_W-1:0] dac_r;

  always_comb begin
    case (fix_sel)
      FIX_5M: fix_div = DIV_5M;
      FIX_1M: fix_div = DIV_1M;
      default: fix_div = DIV_10M;
    endcase
    fix_cnt_nxt = (fix_cnt_r >= fix_div - 4'h1) ? 4'h0 : fix_cnt_r + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fix_cnt_r <= 4'h0;
      fix_out_r <= 1'b0;
      dac_r <= '0;
    end else begin
      fix_cnt_r <= fix_cnt_nxt;
      fix_out_r <= (fix_cnt_r == 4'h0);
      dac_r <= dac_set;
    end
  end

  assign fix_out = fix_out_r;
  assign dac_out = dac_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_hi_read;
    rd_stb && rd_sel == SEL_TIME_HI;
  endsequence

  sequence s_lo_read;
    rd_stb && rd_sel == SEL_TIME_LO;
  endsequence

  sequence s_cmp_match;
    cmp_en && time_r == cmp_time && !cmp_seen_r;
  endsequence

  chk_sub_advance: assert property (
    !set_stb && adv && time_r.sub != SUB_LAST
    |=> time_r.sub == $past(time_r.sub) + 24'h1)
    else $error("Sub-second count did not advance.");

  chk_flywheel_run: assert property (
    !set_stb && gen_mode && !ext_ok |=> time_r != $past(time_r))
    else $error("Time stopped while reference was lost.");

  chk_ext_pacing: assert property (
    !set_stb && gen_mode && ext_ok && !ext_tick |=> time_r == $past(time_r))
    else $error("Time advanced without an external tick.");

  chk_read_answer: assert property (
    rd_stb |=> rd_valid ##1 (rd_valid == $past(rd_stb)))
    else $error("Read answer not given in the next cycle.");

  chk_read_snapshot: assert property (
    s_hi_read ##1 s_lo_read |=> rd_data[23:0] == $past(time_r.sub, 2))
    else $error("Low word does not match the snapshot.");

  chk_cmp_fire: assert property (
    s_cmp_match |=> cmp_out && irq_pend[IRQ_CMP] ##1 !cmp_out)
    else $error("Compare match did not fire once.");

  chk_evt_capture: assert property (
    evt_rise[1] |=> stamp_r[1] == $past(time_r))
    else $error("Event time was not latched.");

  chk_evt_irq: assert property (
    evt_rise[2] |=> irq_pend[IRQ_EVT0 + 2])
    else $error("Event capture raised no pending flag.");

  chk_host_stamp: assert property (
    host_sig |=> stamp_r[HOST_STAMP] == $past(time_r))
    else $error("Host signal time was not recorded.");

  chk_rate_route: assert property (
    rate_tick && rate_route == ROUTE_IRQ |=> irq_pend[IRQ_RATE] && !rate_out)
    else $error("Rate tick routing is wrong.");

  chk_fix_1m: assert property (
    fix_out && fix_sel == FIX_1M ##1 fix_sel == FIX_1M |-> !fix_out)
    else $error("1 MPPS output pulsed twice in a row.");

  chk_pend_clear: assert property (
    irq_clr[IRQ_CMP] && !cmp_hit |=> !irq_pend[IRQ_CMP])
    else $error("Pending flag was not cleared.");

  chk_dac_follow: assert property (
    1'b1 |=> dac_out == $past(dac_set))
    else $error("DAC output did not follow its setting.");

endmodule // time_frequency_core

// ---- ref_source.sv ----
// Model of the external 10 MHz reference that paces the core.
`timescale 1ns/10ps
module ref_source (
  // Controls from the bench
  input wire logic present,
  input wire logic run,
  // Reference seen by the core
  output logic ext_ok,
  output logic ext_tick
);
  // ==========================================================
  // Reference
  // The presence line alone lets the core flywheel on its own oscillator.
  assign ext_ok = present;
  // A tick only exists while the reference is present.
  assign ext_tick = run & present;
endmodule // ref_source

// ---- time_frequency_core_tb.sv ----
// Self-checking testbench of the time and frequency core.
`timescale 1ns/10ps
module time_frequency_core_tb;
  import tfc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic set_stb, gen_mode, present, run, ext_ok, ext_tick, rd_stb, fmt_dec;
  logic rd_valid, cmp_en, cmp_out, host_sig, irq_out, rate_route, rate_out;
  logic fix_out, prev_rate;
  time_t set_time, cmp_time;
  logic [3:0] rd_sel;
  logic [31:0] rd_data, d;
  logic [2:0] evt_in;
  logic [4:0] irq_en, irq_clr, irq_pend;
  logic [47:0] dds_step;
  logic [1:0] fix_sel;
  logic [15:0] dac_set, dac_out;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int n_cmp, n_fix, n_rate;

  always #50 clk_sys = ~clk_sys;

  ref_source i_ref_source (.present(present), .run(run), .ext_ok(ext_ok),
    .ext_tick(ext_tick));

  time_frequency_core i_time_frequency_core (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .set_stb(set_stb), .set_time(set_time),
    .gen_mode(gen_mode), .ext_ok(ext_ok), .ext_tick(ext_tick),
    .rd_stb(rd_stb), .rd_sel(rd_sel), .fmt_dec(fmt_dec), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmp_en(cmp_en), .cmp_time(cmp_time),
    .cmp_out(cmp_out), .evt_in(evt_in), .host_sig(host_sig),
    .irq_en(irq_en), .irq_clr(irq_clr), .irq_pend(irq_pend),
    .irq_out(irq_out), .dds_step(dds_step), .rate_route(rate_route),
    .rate_out(rate_out), .fix_sel(fix_sel), .fix_out(fix_out),
    .dac_set(dac_set), .dac_out(dac_out));

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits n edges, then steps just past the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [3:0] sel, output logic [31:0] data);
    rd_stb = 1'b1;
    rd_sel = sel;
    cyc(1);
    chk(rd_valid, 1);
    data = rd_data;
    rd_stb = 1'b0;
    cyc(1);
  endtask

  // Reads the high word, then the low word in the very next cycle; the low
  // word must come from the snapshot taken with the high word.
  task automatic rdtime(input logic [31:0] hi, input logic [31:0] lo);
    rd_stb = 1'b1;
    rd_sel = SEL_TIME_HI;
    cyc(1);
    chk(rd_valid, 1);
    chk(rd_data, hi);
    rd_sel = SEL_TIME_LO;
    cyc(1);
    chk(rd_valid, 1);
    chk(rd_data, lo);
    rd_stb = 1'b0;
    cyc(1);
  endtask

  task automatic settime(input time_t t);
    set_time = t;
    set_stb = 1'b1;
    cyc(1);
    set_stb = 1'b0;
    cyc(1);
  endtask

  task automatic tick();
    run = 1'b1;
    cyc(1);
    run = 1'b0;
    cyc(2);
  endtask

  task automatic clear_irq();
    irq_clr = 5'h1F;
    cyc(1);
    irq_clr = 5'h00;
    cyc(1);
  endtask

  // ==========================================================
  // Monitors and timeout
  // Outputs are counted on the falling edge, where they have settled.
  always @(negedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
    n_cmp += (cmp_out === 1'b1);
    n_fix += (fix_out === 1'b1);
    n_rate += (rate_out === 1'b1 && prev_rate !== 1'b1);
    prev_rate = rate_out;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {set_stb, run, rd_stb, fmt_dec, cmp_en, host_sig, rate_route} = '0;
    {evt_in, irq_clr, dds_step, fix_sel, dac_set, rd_sel} = '0;
    {set_time, cmp_time} = '0;
    gen_mode = 1'b1;
    present = 1'b1;
    irq_en = 5'h1F;
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    cyc(1);
    chk(irq_pend, 0);
    rdtime(32'h0, 32'h0);
    $display("reset test done");

    // Time is frozen; one reference tick rolls sub, sec, min and hr over and carries into days.
    settime('{days:16'h5, hr:5'h17, min:6'h3B, sec:6'h3B, sub:24'h98967F});
    rdtime(32'h0005173B, 32'h3B98967F);
    fmt_dec = 1'b1;
    rdtime(32'h00052359, 32'h5998967F);
    fmt_dec = 1'b0;
    cmp_time = '{days:16'h6, default:'0};
    cmp_en = 1'b1;
    n_cmp = 0;
    tick();
    cyc(4);
    rdtime(32'h00060000, 32'h0);
    chk(n_cmp, 1);
    chk(irq_pend, 5'h01);
    chk(irq_out, 1);
    irq_en = 5'h00;
    cyc(1);
    chk(irq_out, 0);
    clear_irq();
    chk(irq_pend, 0);
    irq_en = 5'h1F;
    cmp_en = 1'b0;
    present = 1'b0;
    cyc(20);
    present = 1'b1;
    rd(4'h0, d);
    rd(4'h1, d);
    chk(d, 32'h0000_0014);
    gen_mode = 1'b0;
    cyc(30);
    gen_mode = 1'b1;
    rd(4'h0, d);
    rd(4'h1, d);
    chk(d, 32'h0000_0032);
    $display("time and compare test done");

    for (int i = 0; i < 4; i++) begin
      settime('{days:16'(i + 1), default:'0});
      if (i < 3) evt_in[i] = 1'b1;
      else host_sig = 1'b1;
      cyc(1);
      evt_in = 3'h0;
      host_sig = 1'b0;
      cyc(1);
      rd(4'(2 + 2 * i), d);
      chk(d, {16'(i + 1), 16'h0});
      rd(4'(3 + 2 * i), d);
      chk(d, 32'h0);
      chk(irq_pend, (i < 3) ? 5'(2 << i) : 5'h0);
      clear_irq();
    end
    rd(4'hA, d);
    chk(d, 32'h0);
    $display("capture test done");

    dds_step = 48'h4000_0000_0000;
    cyc(4);
    n_rate = 0;
    cyc(40);
    chk(n_rate, 10);
    rate_route = 1'b1;
    cyc(4);
    clear_irq();
    n_rate = 0;
    cyc(10);
    chk(n_rate, 0);
    chk(irq_pend[4], 1);
    for (int k = 0; k < 4; k++) begin
      fix_sel = 2'(k);
      cyc(12);
      n_fix = 0;
      cyc(20);
      chk(n_fix, (k == 1) ? 10 : (k == 2) ? 2 : 20);
    end
    dac_set = 16'hA5C3;
    cyc(1);
    chk(dac_out, 16'hA5C3);
    $display("rate and output test done");
    summarize();
  end
endmodule // time_frequency_core_tb
